// >>> dv/tb_top.sv
`timescale 1ns/1ns
`include "tslr_map.vh"
// Self-checking bench driving APB and the step port
module tb_top;
    reg clk = 1'b0; // Clock
    reg reset = 1'b1; // Sync reset
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
    reg [11:0] paddr = 12'h000; // APB address
    reg [31:0] pwdata = 32'h0000_0000; // APB write data
    reg [3:0] pstrb = 4'h0; // APB strobes
    reg step_valid = 1'b0; // Step offer
    reg [2:0] step_op = 3'h0; // Step opcode
    reg [4:0] step_arg = 5'h00; // Step argument
    wire [31:0] prdata, trig_q; // Read data, triggers
    wire pready, pslverr, step_done_q; // Handshakes
    wire [15:0] literal_q, t0o, t1o; // Engine-facing values
    wire [4:0] qptr_q; // Queue pointer
    integer err_count = 0, check_count = 0, i, cyc, d0;
    reg [31:0] rd, trig_seen, pat; // Captured values
    reg err; // Captured pslverr
    tslr_bank tslr_bank_inst (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .step_valid(step_valid),
        .step_op(step_op), .step_arg(step_arg),
        .step_done_q(step_done_q), .trig_q(trig_q),
        .literal_q(literal_q), .qptr_q(qptr_q), .t0_lim_out_q(t0o),
        .t1_lim_out_q(t1o));
    // Clock source
    initial begin
        forever #10 clk = ~clk;
    end
    // Compare and count
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer; read data lands in rd, response in err
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            pstrb <= 4'hf;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n >= 50) err_count = err_count + 1;
        end
    endtask
    // Offer one step, wait for done, note any trigger pulse
    task step(input [2:0] op, input [4:0] arg);
        begin
            @(posedge clk);
            step_valid <= 1'b1;
            step_op <= op;
            step_arg <= arg;
            @(posedge clk);
            step_valid <= 1'b0;
            cyc = 0;
            trig_seen = 32'h0000_0000;
            while (step_done_q !== 1'b1 && cyc < 200) begin
                @(posedge clk);
                if (trig_q !== 32'h0000_0000) trig_seen = trig_q;
                cyc = cyc + 1;
            end
            if (cyc >= 200) err_count = err_count + 1;
        end
    endtask
    // Verdict and end of run
    task final_report;
        begin
            if (err_count == 0 && check_count > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    // Reset values, exact readback, upper half reads zero
    task s_reset_rw;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                apb(1'b0, i * 4, 32'h0000_0000);
                chk(rd, 32'h0000_0000);
                pat = 32'hffff_0000 | ((i + 1) * 32'h0000_1111);
                apb(1'b1, i * 4, pat);
                apb(1'b0, i * 4, 32'h0000_0000);
                chk(rd, pat & 32'h0000_ffff);
            end
            chk({16'h0000, t0o}, 32'h0000_4444);
            chk({16'h0000, t1o}, 32'h0000_5555);
            apb(1'b1, 12'h040, 32'h0000_0001);
            chk({31'h0, err}, 32'h0000_0001);
        end
    endtask
    // Broadcast with split mask, then writes locked while running
    task s_bcast_lock;
        begin
            apb(1'b1, `TSLR_OFF_SD_LIM, 32'h0000_0000);
            apb(1'b1, `TSLR_OFF_BCAST_LO, 32'h0000_8003);
            apb(1'b1, `TSLR_OFF_BCAST_HI, 32'h0000_8001);
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0080);
            step(`TSLR_OP_BCAST, 5'h00);
            chk(trig_seen, 32'h8001_8003);
            apb(1'b1, `TSLR_OFF_HOLD, 32'h0000_1234);
            apb(1'b0, `TSLR_OFF_HOLD, 32'h0000_0000);
            chk(rd, 32'h0000_3333);
        end
    endtask
    // Copy hold into every target
    task s_copy;
        begin
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0000);
            apb(1'b1, `TSLR_OFF_HOLD, 32'h0000_0003);
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0080);
            for (i = 0; i < 5; i = i + 1) begin
                step(`TSLR_OP_COPY, i);
                apb(1'b0, `TSLR_OFF_T0_LIM + i * 4, 32'h0000_0000);
                chk(rd, 32'h0000_0003);
            end
            step(`TSLR_OP_COPY, `TSLR_TGT_LIT);
            chk({16'h0000, literal_q}, 32'h0000_0003);
        end
    endtask
    // Loops on both counters, with a live count read
    task s_jump;
        begin
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0000);
            apb(1'b1, `TSLR_OFF_C0_LIM, 32'h0000_0002);
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0080);
            for (i = 0; i < 3; i = i + 1) begin
                step(`TSLR_OP_JMPC0, 5'h09);
                chk({27'h0, qptr_q}, (i < 2) ? 32'h9 : 32'ha);
                if (i == 0) begin
                    apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0180);
                    apb(1'b0, `TSLR_OFF_C0_LIM, 32'h0000_0000);
                    chk(rd, 32'h0000_0001);
                    apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0080);
                end
            end
            step(`TSLR_OP_JMPC1, 5'h11);
            chk({27'h0, qptr_q}, 32'h0000_0011);
        end
    endtask
    // Step delay adds exactly its limit in clocks
    task s_delay;
        begin
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0000);
            apb(1'b1, `TSLR_OFF_SD_LIM, 32'h0000_0000);
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0080);
            step(`TSLR_OP_DELAY, 5'h00);
            d0 = cyc;
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0000);
            apb(1'b1, `TSLR_OFF_SD_LIM, 32'h0000_0006);
            apb(1'b1, `TSLR_OFF_CTRL, 32'h0000_0080);
            step(`TSLR_OP_DELAY, 5'h00);
            chk(cyc - d0, 32'h0000_0006);
        end
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        s_reset_rw;
        s_bcast_lock;
        s_copy;
        s_jump;
        s_delay;
        final_report;
    end
    // Watchdog against hangs
    initial begin
        #200000;
        err_count = err_count + 1;
        final_report;
    end
endmodule

// >>> dv/tslr_bank_properties.sv
`timescale 1ns/1ns
// Port-level checker for the limit register bank
module tslr_bank_properties (
    input wire clk, // Clock
    input wire reset, // Sync reset
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    input wire [3:0] pstrb, // APB strobes
    input wire [31:0] prdata, // APB read data
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire step_valid, // Step offered
    input wire [2:0] step_op, // Step opcode
    input wire [4:0] step_arg, // Step argument
    input wire step_done_q, // Step done
    input wire [31:0] trig_q, // Triggers
    input wire [15:0] literal_q, // Literal
    input wire [4:0] qptr_q, // Queue pointer
    input wire [15:0] t0_lim_out_q, // Timer 0 limit
    input wire [15:0] t1_lim_out_q // Timer 1 limit
);
    // Access edge not yet answered
    wire acc = psel && penable && !pready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_READY_NEXT: assert property (acc |=> pready)
        else $error("pready missing after access edge");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_UNMAPPED_ERR: assert property (acc && paddr > 12'h027 |=> pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (acc && paddr < 12'h028 &&
        paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("bank access refused");
    AST_TRIG_PULSE: assert property (trig_q != 0 |=> trig_q == 0)
        else $error("trigger pulse too long");
    AST_DONE_PULSE: assert property (step_done_q |=> !step_done_q)
        else $error("done pulse too long");
    // Timer 0 limit moves only by a write or a copy step
    AST_T0_CAUSE: assert property ($changed(t0_lim_out_q) |->
        $past(psel && penable && pready && pwrite && paddr == 12'h00C, 2) ||
        $past(step_valid) || $past(step_valid, 2) ||
        $past(step_valid, 3) || $past(reset))
        else $error("timer 0 limit changed without cause");
    AST_QPTR_CAUSE: assert property ($changed(qptr_q) |->
        $past(step_valid) || $past(step_valid, 2) || $past(step_valid, 3) ||
        $past(psel && penable && pready && pwrite && paddr == 12'h020, 2) ||
        $past(reset))
        else $error("queue pointer changed without a step or a stop");
endmodule
bind tslr_bank tslr_bank_properties tslr_bank_properties_inst (.*);

// >>> verilog/tslr_bank.v
`timescale 1ns/1ns
`include "tslr_map.vh"
module tslr_bank (
    input wire clk, // Clock, 50 MHz
    input wire reset, // Sync reset, active high
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    input wire [3:0] pstrb, // APB byte strobes
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error
    input wire step_valid, // Step command from engine
    input wire [2:0] step_op, // Step opcode
    input wire [4:0] step_arg, // Target or jump address
    output reg step_done_q, // Step command completed
    output reg [31:0] trig_q, // Trigger outputs
    output reg [15:0] literal_q, // Literal register
    output reg [4:0] qptr_q, // Step queue pointer
    output reg [15:0] t0_lim_out_q, // Timer 0 limit to engine
    output reg [15:0] t1_lim_out_q // Timer 1 limit to engine
);
    // Bank registers
    reg [15:0] bcast_lo_q; // Broadcast enables 0-15
    reg [15:0] bcast_hi_q; // Broadcast enables 16-31
    reg [15:0] hold_q; // Hold value
    reg [15:0] t0_lim_q; // Timer 0 limit
    reg [15:0] t1_lim_q; // Timer 1 limit
    reg [15:0] sd_lim_q; // Step delay limit
    reg [15:0] c0_lim_q; // Counter 0 limit
    reg [15:0] c1_lim_q; // Counter 1 limit
    reg vis_q; // Visibility control
    reg run_q; // Sequencer executing
    // Step engine state
    // Idle, exec, wait: one step at a time
    localparam ST_IDLE = 2'h0; // Waiting for a step
    localparam ST_EXEC = 2'h1; // Performing the step
    localparam ST_WAIT = 2'h2; // Step delay running
    reg [1:0] state_q; // Engine state
    reg [1:0] state_d; // Next engine state
    reg [2:0] op_q; // Latched opcode
    reg [4:0] arg_q; // Latched argument
    reg [3:0] pulse_q; // Trigger pulse remaining
    // Live counts, read back when visibility is set
    wire [15:0] sd_count; // Live step delay count
    wire sd_busy; // Step delay running
    wire [15:0] c0_count; // Live counter 0
    wire [15:0] c1_count; // Live counter 1
    wire c0_at; // Counter 0 at limit
    wire c1_at; // Counter 1 at limit
    wire [15:0] t0_count; // Live timer 0
    wire [15:0] t1_count; // Live timer 1
    // Strobes derived from the engine state
    wire exec; // Step executes this cycle
    wire jump0; // Counter 0 jump executes
    wire jump1; // Counter 1 jump executes
    // Bus decode helpers
    wire apb_wr; // APB write completing
    wire apb_rd; // APB read access phase
    wire wr_ok; // Write allowed to bank
    wire [15:0] wdata16; // Low half of write data, strobes not applied
    // Read path
    reg [31:0] rdata_d; // Read mux result
    reg err_d; // Unmapped address

    // Decodes shared by the processes below
    assign exec = (state_q == ST_EXEC);
    assign jump0 = exec && (op_q == `TSLR_OP_JMPC0);
    assign jump1 = exec && (op_q == `TSLR_OP_JMPC1);
    // A write lands at the edge that completes the transfer,
    // the one at which the master sees pready high
    assign apb_wr = psel && penable && pwrite && pready;
    // Read data is captured one edge earlier, so it stands with pready
    assign apb_rd = psel && penable && !pwrite && !pready;
    // Only the control register stays writable while running
    assign wr_ok = apb_wr && !run_q;
    assign wdata16 = pwdata[15:0];

    // Step delay timer, restarted as each step starts
    // A zero limit leaves it idle, so no delay is added
    tslr_step_timer #(.W(16)) u_sd (
        .clk(clk),
        .reset(reset),
        .start(exec),
        .limit(sd_lim_q),
        .count_q(sd_count),
        .busy_q(sd_busy)
    );

    // General-purpose timer 0 runs while the sequencer runs
    // It restarts at its limit and is held at zero while stopped
    tslr_step_timer #(.W(16)) u_t0 (
        .clk(clk),
        .reset(reset),
        .start(!run_q || (t0_count == t0_lim_q)),
        .limit(t0_lim_q),
        .count_q(t0_count),
        .busy_q()
    );

    // General-purpose timer 1, its own limit
    // Same restart rule as timer 0
    tslr_step_timer #(.W(16)) u_t1 (
        .clk(clk),
        .reset(reset),
        .start(!run_q || (t1_count == t1_lim_q)),
        .limit(t1_lim_q),
        .count_q(t1_count),
        .busy_q()
    );

    // Loop counter 0
    // Cleared whenever the sequencer stops, so each run starts fresh
    tslr_loop_ctr #(.W(16)) u_c0 (
        .clk(clk),
        .reset(reset),
        .limit(c0_lim_q),
        .jump(jump0),
        .clear(!run_q),
        .count_q(c0_count),
        .at_limit(c0_at)
    );

    // Loop counter 1
    // Same clearing rule as counter 0
    tslr_loop_ctr #(.W(16)) u_c1 (
        .clk(clk),
        .reset(reset),
        .limit(c1_lim_q),
        .jump(jump1),
        .clear(!run_q),
        .count_q(c1_count),
        .at_limit(c1_at)
    );

    // Engine next state
    // A step is taken only while idle and running
    // Exec lasts one clock; the step delay follows it
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (step_valid && run_q) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                // Delay adds limit clocks before completion
                if (!sd_busy) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Engine state, latched command, completion strobe
    // Opcode and argument are latched as the step is taken,
    // so the engine may drop step_valid right after
    always @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            op_q <= 3'h0;
            arg_q <= 5'h00;
            step_done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // Done is raised in the clock that wait ends
            step_done_q <= (state_q == ST_WAIT) && !sd_busy;
            if (state_q == ST_IDLE && step_valid && run_q) begin
                op_q <= step_op;
                arg_q <= step_arg;
            end
        end
    end

    // Trigger outputs: broadcast pulse on enabled bits only
    // Outputs whose mask bits are clear stay low
    // A new broadcast restarts the pulse
    always @(posedge clk) begin
        if (reset) begin
            trig_q <= 32'h0000_0000;
            pulse_q <= 4'h0;
        end else if (exec && op_q == `TSLR_OP_BCAST) begin
            // Upper register drives outputs 16 to 31
            trig_q <= {bcast_hi_q, bcast_lo_q};
            pulse_q <= `TSLR_PULSE_CYCLES;
        end else if (pulse_q > 4'h1) begin
            pulse_q <= pulse_q - 4'h1;
        end else begin
            trig_q <= 32'h0000_0000;
            pulse_q <= 4'h0;
        end
    end

    // Queue pointer: conditional jumps, else advance per step
    // A jump short of its limit loads the argument;
    // any other step, a jump at its limit included, advances
    // Stopping the sequencer returns the pointer to zero
    always @(posedge clk) begin
        if (reset) begin
            qptr_q <= 5'h00;
        end else if (!run_q) begin
            qptr_q <= 5'h00;
        end else if ((jump0 && !c0_at) || (jump1 && !c1_at)) begin
            qptr_q <= arg_q;
        end else if (exec) begin
            qptr_q <= qptr_q + 5'h01;
        end
    end

    // Bank registers: software writes when stopped, copy step loads
    // Control stays writable so software can always stop;
    // a copy step and a software write never meet, since
    // software writes are refused while the sequencer runs
    always @(posedge clk) begin
        if (reset) begin
            // Every register clears to zero
            bcast_lo_q <= `TSLR_RESET_16;
            bcast_hi_q <= `TSLR_RESET_16;
            hold_q <= `TSLR_RESET_16;
            t0_lim_q <= `TSLR_RESET_16;
            t1_lim_q <= `TSLR_RESET_16;
            sd_lim_q <= `TSLR_RESET_16;
            c0_lim_q <= `TSLR_RESET_16;
            c1_lim_q <= `TSLR_RESET_16;
            literal_q <= `TSLR_RESET_16;
            vis_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            // Visibility lives in the upper byte, run in the lower
            if (apb_wr && paddr == `TSLR_OFF_CTRL && pstrb[1]) begin
                vis_q <= pwdata[`TSLR_CTRL_VIS_BIT];
            end
            if (apb_wr && paddr == `TSLR_OFF_CTRL && pstrb[0]) begin
                run_q <= pwdata[`TSLR_CTRL_RUN_BIT];
            end
            // Bank registers need both low byte strobes
            if (wr_ok && pstrb[1:0] == 2'b11) begin
                case (paddr)
                    `TSLR_OFF_BCAST_LO: bcast_lo_q <= wdata16;
                    `TSLR_OFF_BCAST_HI: bcast_hi_q <= wdata16;
                    `TSLR_OFF_HOLD: hold_q <= wdata16;
                    `TSLR_OFF_T0_LIM: t0_lim_q <= wdata16;
                    `TSLR_OFF_T1_LIM: t1_lim_q <= wdata16;
                    `TSLR_OFF_SD_LIM: sd_lim_q <= wdata16;
                    `TSLR_OFF_C0_LIM: c0_lim_q <= wdata16;
                    `TSLR_OFF_C1_LIM: c1_lim_q <= wdata16;
                    default: begin
                    end
                endcase
            end
            if (exec && op_q == `TSLR_OP_COPY) begin
                // Hold value into selected target
                case (arg_q[2:0])
                    `TSLR_TGT_T0: t0_lim_q <= hold_q;
                    `TSLR_TGT_T1: t1_lim_q <= hold_q;
                    `TSLR_TGT_SD: sd_lim_q <= hold_q;
                    `TSLR_TGT_C0: c0_lim_q <= hold_q;
                    `TSLR_TGT_C1: c1_lim_q <= hold_q;
                    `TSLR_TGT_LIT: literal_q <= hold_q;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Limits forwarded to the engine timers
    // Registered copies, one clock behind the bank registers
    always @(posedge clk) begin
        if (reset) begin
            t0_lim_out_q <= `TSLR_RESET_16;
            t1_lim_out_q <= `TSLR_RESET_16;
        end else begin
            t0_lim_out_q <= t0_lim_q;
            t1_lim_out_q <= t1_lim_q;
        end
    end

    // Read mux, live values when visibility is set
    // The upper half of every bank word reads as zero
    // An address not decoded here answers with an error
    always @* begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        case (paddr)
            `TSLR_OFF_BCAST_LO: rdata_d[15:0] = bcast_lo_q;
            `TSLR_OFF_BCAST_HI: rdata_d[15:0] = bcast_hi_q;
            `TSLR_OFF_HOLD: rdata_d[15:0] = hold_q;
            `TSLR_OFF_T0_LIM: rdata_d[15:0] = vis_q ? t0_count : t0_lim_q;
            `TSLR_OFF_T1_LIM: rdata_d[15:0] = vis_q ? t1_count : t1_lim_q;
            `TSLR_OFF_SD_LIM: rdata_d[15:0] = vis_q ? sd_count : sd_lim_q;
            `TSLR_OFF_C0_LIM: rdata_d[15:0] = vis_q ? c0_count : c0_lim_q;
            `TSLR_OFF_C1_LIM: rdata_d[15:0] = vis_q ? c1_count : c1_lim_q;
            // Control reads back both of its bits
            `TSLR_OFF_CTRL: begin
                rdata_d[`TSLR_CTRL_VIS_BIT] = vis_q;
                rdata_d[`TSLR_CTRL_RUN_BIT] = run_q;
            end
            `TSLR_OFF_STATUS: rdata_d[`TSLR_STAT_BUSY_BIT] = (state_q != ST_IDLE);
            default: err_d = 1'b1;
        endcase
    end

    // APB answer one cycle into the access phase
    // Every transfer waits one clock in its access phase;
    // error stands only while pready is high; read data holds until the next read
    always @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            // Answer the first access edge only
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && err_d;
            // Capture read data on the same edge
            if (apb_rd) begin
                prdata <= rdata_d;
            end
        end
    end
endmodule

// >>> verilog/tslr_loop_ctr.v
`timescale 1ns/1ns
// One loop counter with conditional jump decision
module tslr_loop_ctr #(
    parameter W = 16
) (
    input wire clk, // Clock
    input wire reset, // Sync reset, active high
    input wire [W-1:0] limit, // Terminal count
    input wire jump, // Conditional jump executes
    input wire clear, // Clear counter
    output reg [W-1:0] count_q, // Current count
    output wire at_limit // Count equals limit
);
    assign at_limit = (count_q == limit);

    // Count up on each non-terminal jump, wrap to zero at limit
    always @(posedge clk) begin
        if (reset || clear) begin
            count_q <= {W{1'b0}};
        end else if (jump) begin
            if (at_limit) begin
                count_q <= {W{1'b0}};
            end else begin
                count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// >>> verilog/tslr_map.vh
`ifndef TSLR_MAP_VH
`define TSLR_MAP_VH
// Register byte offsets on the APB slave
`define TSLR_OFF_BCAST_LO 12'h000
`define TSLR_OFF_BCAST_HI 12'h004
`define TSLR_OFF_HOLD 12'h008
`define TSLR_OFF_T0_LIM 12'h00C
`define TSLR_OFF_T1_LIM 12'h010
`define TSLR_OFF_SD_LIM 12'h014
`define TSLR_OFF_C0_LIM 12'h018
`define TSLR_OFF_C1_LIM 12'h01C
`define TSLR_OFF_CTRL 12'h020
`define TSLR_OFF_STATUS 12'h024
// Control register fields
`define TSLR_CTRL_VIS_BIT 8
`define TSLR_CTRL_RUN_BIT 7
// Status register fields
`define TSLR_STAT_BUSY_BIT 0
// Reset value of every bank register
`define TSLR_RESET_16 16'h0000
// Copy command target selects
`define TSLR_TGT_T0 3'h0
`define TSLR_TGT_T1 3'h1
`define TSLR_TGT_SD 3'h2
`define TSLR_TGT_C0 3'h3
`define TSLR_TGT_C1 3'h4
`define TSLR_TGT_LIT 3'h5
// Step engine opcodes
`define TSLR_OP_BCAST 3'h1
`define TSLR_OP_COPY 3'h2
`define TSLR_OP_JMPC0 3'h3
`define TSLR_OP_JMPC1 3'h4
`define TSLR_OP_DELAY 3'h5
// Trigger pulse width in clocks
`define TSLR_PULSE_CYCLES 4'h1
`endif

// >>> verilog/tslr_step_timer.v
`timescale 1ns/1ns
// Free timer counting toward a limit, used for step delay and timers
module tslr_step_timer #(
    parameter W = 16
) (
    input wire clk, // Clock
    input wire reset, // Sync reset, active high
    input wire start, // Restart from zero
    input wire [W-1:0] limit, // Terminal count
    output reg [W-1:0] count_q, // Current count
    output reg busy_q // Counting in progress
);
    // Run from zero up to the limit, then stop
    always @(posedge clk) begin
        if (reset) begin
            count_q <= {W{1'b0}};
            busy_q <= 1'b0;
        end else if (start) begin
            count_q <= {W{1'b0}};
            busy_q <= (limit != {W{1'b0}});
        end else if (busy_q) begin
            if (count_q + {{(W-1){1'b0}}, 1'b1} >= limit) begin
                busy_q <= 1'b0;
            end
            count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule
